// >>> core/mac_pkg.sv
// Shared widths, reset values, modes and carrier types of the multiply-accumulate slice
package mac_pkg;

  // Datapath widths
  localparam int unsigned MAC_OPER_W = 16;
  localparam int unsigned MAC_HALF_W = 16;
  localparam int unsigned MAC_ACC_W  = 32;
  localparam int unsigned MAC_NARROW_W = 8;
  localparam int unsigned MAC_HALVES = 2;

  // Field positions within the 32-bit accumulator
  localparam int unsigned MAC_LO_LSB = 0;
  localparam int unsigned MAC_HI_LSB = 16;
  localparam int unsigned MAC_SIGN_BIT = 31;

  // Reset values
  localparam logic [15:0] MAC_OPER_RST = 16'h0000;
  localparam logic [31:0] MAC_ACC_RST  = 32'h0000_0000;
  localparam logic        MAC_FLAG_RST = 1'b0;

  // Function of the slice
  typedef enum logic [2:0] {
    MAC_MUL8  = 3'b000,
    MAC_MUL16 = 3'b001,
    MAC_ADD16 = 3'b010,
    MAC_ADD32 = 3'b011,
    MAC_ACC16 = 3'b100,
    MAC_ACC32 = 3'b101,
    MAC_MAC8  = 3'b110,
    MAC_MAC16 = 3'b111
  } mac_mode_e;

  // Registered operands
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
    logic [15:0] d;
  } mac_operands_s;

  // Per-half accumulator controls
  typedef struct packed {
    logic loadSel;
    logic subSel;
  } mac_half_ctrl_s;

endpackage : mac_pkg

// >>> core/mac_half_acc.sv
// One 16-bit adder/subtracter half with load bypass and carry/borrow chaining
`timescale 1ns/1ps
module mac_half_acc
  import mac_pkg::*;
#(
  parameter int unsigned WIDTH = MAC_HALF_W
)
(
  // Operands
  input  wire logic [WIDTH-1:0] base,
  input  wire logic [WIDTH-1:0] addend,
  input  wire logic [WIDTH-1:0] loadVal,
  // Controls
  input  wire logic             subSel,
  input  wire logic             loadSel,
  input  wire logic             carryIn,
  // Results
  output logic      [WIDTH-1:0] nextVal,
  output logic                  carryOut
);

  logic [WIDTH:0] sum;

  // Borrow is carried as an active-high flag in both directions, so that a
  // chain of halves or slices subtracts with the same wiring as it adds
  always_comb
  begin
    sum = {1'b0, base}
        + {1'b0, (subSel ? ~addend : addend)}
        + {{WIDTH{1'b0}}, (subSel ? ~carryIn : carryIn)};
    if (loadSel)
    begin
      nextVal  = loadVal;
      carryOut = 1'b0;
    end
    else
    begin
      nextVal  = sum[WIDTH-1:0];
      carryOut = subSel ? ~sum[WIDTH] : sum[WIDTH];
    end
  end

endmodule : mac_half_acc

// >>> core/mac_slice.sv
// Multiply-accumulate slice: operand registers, multiplier and two-half accumulator
//
// Overview of operation
// - One clock times every register
// - Clock gate high updates, low holds all
// - A and B registered, multiply or add, zero default
// - C and D registered, adder only, zero default
// - Hold input freezes the A register
// - Lower load select: sum or C operand
// - Lower subtract select: add or subtract
// - Cascade carry/borrow in and out chain slices
// - Tile carry/borrow in and out to logic
// - Sign extension passed between cascaded slices
// - Eight multiply, add and accumulate functions
// - 8x8 product uses the upper half only
`timescale 1ns/1ps
module mac_slice
  import mac_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  srst,
  // Configuration
  input  wire mac_pkg::mac_mode_e    mode,
  input  wire logic                  signedOps,
  input  wire logic                  cascadeMode,
  // Clock gate and operand hold
  input  wire logic                  sliceClockGate,
  input  wire logic                  holdFirstOperand,
  // Operands
  input  wire logic [15:0]           opA,
  input  wire logic [15:0]           opB,
  input  wire logic [15:0]           opC,
  input  wire logic [15:0]           opD,
  // Accumulator controls
  input  wire logic                  lowerAccLoadSelect,
  input  wire logic                  lowerAccSubSelect,
  input  wire mac_pkg::mac_half_ctrl_s upperAccCtrl,
  // Carry and sign links
  input  wire logic                  cascadeCarryIn,
  input  wire logic                  tileCarryIn,
  input  wire logic                  signExtendFromPrev,
  output logic                       cascadeCarryOut,
  output logic                       tileCarryOut,
  output logic                       signExtendToNext,
  // Result
  output logic [31:0]                result
);

  import mac_pkg::*;

  // Operand and accumulator state
  mac_operands_s   oper_q;
  mac_operands_s   oper_d;
  logic [31:0]     acc_q;
  logic [31:0]     acc_d;
  logic            carry_q;
  logic            carry_d;
  logic            sign_q;
  logic            sign_d;

  // Datapath nets
  logic [31:0]     prodWide;
  logic [15:0]     prodNarrow;
  logic [31:0]     baseWord;
  logic [31:0]     addendWord;
  logic [31:0]     loadWord;
  logic            wideMode;
  logic            accMode;
  logic            mulOnly;
  logic [15:0]     halfBase    [MAC_HALVES];
  logic [15:0]     halfAddend  [MAC_HALVES];
  logic [15:0]     halfLoadVal [MAC_HALVES];
  logic [15:0]     halfNext    [MAC_HALVES];
  logic            halfSub     [MAC_HALVES];
  logic            halfLoad    [MAC_HALVES];
  logic            halfCin     [MAC_HALVES];
  logic            halfCout    [MAC_HALVES];

  // Operand capture; a low clock gate freezes every register in the slice
  always_comb
  begin
    oper_d = oper_q;
    if (sliceClockGate)
    begin
      if (!holdFirstOperand)
      begin
        oper_d.a = opA;
      end
      oper_d.b = opB;
      oper_d.c = opC;
      oper_d.d = opD;
    end
  end

  // Operand registers share the single slice clock
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      oper_q <= '{a: MAC_OPER_RST, b: MAC_OPER_RST, c: MAC_OPER_RST, d: MAC_OPER_RST};
    end
    else
    begin
      oper_q <= oper_d;
    end
  end

  // Multipliers read only A and B; C and D never reach them
  always_comb
  begin
    if (signedOps)
    begin
      prodWide   = 32'($signed(oper_q.a) * $signed(oper_q.b));
      prodNarrow = 16'($signed(oper_q.a[7:0]) * $signed(oper_q.b[7:0]));
    end
    else
    begin
      prodWide   = 32'(oper_q.a * oper_q.b);
      prodNarrow = 16'(oper_q.a[7:0] * oper_q.b[7:0]);
    end
  end

  // Mode decode: which operands meet in each half and whether halves chain
  always_comb
  begin
    wideMode   = 1'b0;
    accMode    = 1'b0;
    mulOnly    = 1'b0;
    baseWord   = {oper_q.c, oper_q.d};
    addendWord = {oper_q.a, oper_q.b};
    unique case (mode)
      MAC_MUL8:
      begin
        // Product lives in the upper half; lower half stays a free D+B adder
        mulOnly    = 1'b1;
        baseWord   = {16'h0000, oper_q.d};
        addendWord = {prodNarrow, oper_q.b};
      end
      MAC_MUL16:
      begin
        wideMode   = 1'b1;
        mulOnly    = 1'b1;
        baseWord   = MAC_ACC_RST;
        addendWord = prodWide;
      end
      MAC_ADD16:
      begin
        baseWord   = {oper_q.c, oper_q.d};
        addendWord = {oper_q.a, oper_q.b};
      end
      MAC_ADD32:
      begin
        wideMode   = 1'b1;
        baseWord   = {oper_q.c, oper_q.d};
        addendWord = {oper_q.a, oper_q.b};
      end
      MAC_ACC16:
      begin
        accMode    = 1'b1;
        baseWord   = acc_q;
        addendWord = {oper_q.a, oper_q.b};
      end
      MAC_ACC32:
      begin
        wideMode   = 1'b1;
        accMode    = 1'b1;
        baseWord   = acc_q;
        addendWord = {oper_q.a, oper_q.b};
      end
      MAC_MAC8:
      begin
        accMode    = 1'b1;
        baseWord   = acc_q;
        addendWord = {prodNarrow, oper_q.b};
      end
      MAC_MAC16:
      begin
        wideMode   = 1'b1;
        accMode    = 1'b1;
        baseWord   = acc_q;
        addendWord = prodWide;
      end
    endcase
    // A continuing slice accumulates the previous slice's sign fill
    if (cascadeMode && accMode)
    begin
      addendWord = {32{signExtendFromPrev}};
    end
  end

  // Load bypass: lower half takes C, upper half takes D
  assign loadWord = {oper_q.d, oper_q.c};

  // Per-half controls and carry routing
  always_comb
  begin
    // Lower half
    halfSub[0]  = lowerAccSubSelect & ~mulOnly;
    halfLoad[0] = lowerAccLoadSelect & ~mulOnly;
    // Previous slice carry wins only when this slice continues a chain
    halfCin[0]  = cascadeMode ? cascadeCarryIn : tileCarryIn;
    // Upper half follows the lower controls when chained to 32 bits
    halfSub[1]  = (wideMode ? lowerAccSubSelect : upperAccCtrl.subSel) & ~mulOnly;
    halfLoad[1] = (wideMode ? lowerAccLoadSelect : upperAccCtrl.loadSel) & ~mulOnly;
    halfCin[1]  = wideMode ? halfCout[0] : 1'b0;
  end

  // Two identical halves of the adder/subtracter-accumulator
  for (genvar h = 0; h < MAC_HALVES; h++)
  begin : g_half
    assign halfBase[h]    = baseWord[h*MAC_HALF_W +: MAC_HALF_W];
    assign halfAddend[h]  = addendWord[h*MAC_HALF_W +: MAC_HALF_W];
    assign halfLoadVal[h] = loadWord[h*MAC_HALF_W +: MAC_HALF_W];

    mac_half_acc #(
      .WIDTH (MAC_HALF_W)
    ) u_half (
      .base     (halfBase[h]),
      .addend   (halfAddend[h]),
      .loadVal  (halfLoadVal[h]),
      .subSel   (halfSub[h]),
      .loadSel  (halfLoad[h]),
      .carryIn  (halfCin[h]),
      .nextVal  (halfNext[h]),
      .carryOut (halfCout[h])
    );
  end

  // Accumulator, carry and sign next values; all hold while the gate is low
  always_comb
  begin
    acc_d   = acc_q;
    carry_d = carry_q;
    sign_d  = sign_q;
    if (sliceClockGate)
    begin
      acc_d   = {halfNext[1], halfNext[0]};
      carry_d = halfCout[1];
      // Sign of what was added, so the next slice can extend it
      sign_d  = addendWord[MAC_SIGN_BIT] & signedOps;
    end
  end

  // Accumulator registers; outputs come straight from these flops
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      acc_q   <= MAC_ACC_RST;
      carry_q <= MAC_FLAG_RST;
      sign_q  <= MAC_FLAG_RST;
    end
    else
    begin
      acc_q   <= acc_d;
      carry_q <= carry_d;
      sign_q  <= sign_d;
    end
  end

  // Carry out is registered, so a chained slice lags by exactly one cycle;
  // sign is registered the same way so both arrive together downstream
  assign result           = acc_q;
  assign cascadeCarryOut  = carry_q;
  assign tileCarryOut     = carry_q;
  assign signExtendToNext = sign_q;

endmodule : mac_slice

// >>> tb/mac_link_model.sv
// Neighbour model: previous slice and lower logic tile driving the carry and sign links
`timescale 1ns/1ps
module mac_link_model
(
  // Clock and level to present
  input  wire logic clock,
  input  wire logic linkLevel,
  // Links into the slice
  output logic      cascadeCarryIn,
  output logic      tileCarryIn,
  output logic      signExtendFromPrev
);
  // Registered like a real neighbour, so a change lands one edge late
  always_ff @(posedge clock)
  begin
    cascadeCarryIn     <= linkLevel;
    tileCarryIn        <= linkLevel;
    signExtendFromPrev <= linkLevel;
  end
endmodule : mac_link_model

// >>> tb/mac_slice_sva.sv
// Checker for the multiply-accumulate slice ports
`timescale 1ns/1ps
module mac_slice_sva
  import mac_pkg::*;
(
  // Watched ports
  input wire logic              clock,
  input wire logic              srst,
  input wire mac_pkg::mac_mode_e mode,
  input wire logic              signedOps,
  input wire logic              cascadeMode,
  input wire logic              sliceClockGate,
  input wire logic              holdFirstOperand,
  input wire logic [15:0]       opA,
  input wire logic [15:0]       opB,
  input wire logic [15:0]       opC,
  input wire logic [15:0]       opD,
  input wire logic              lowerAccLoadSelect,
  input wire logic              lowerAccSubSelect,
  input wire logic              tileCarryIn,
  input wire logic              cascadeCarryOut,
  input wire logic              tileCarryOut,
  input wire logic              signExtendToNext,
  input wire logic [31:0]       result
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // Plain cases only: no tile carry in, cascade or operand hold, so carries and sign fill cannot disturb the sums
  logic [63:0] ops;
  logic        base;
  assign ops  = {opA, opB, opC, opD};
  assign base = sliceClockGate && !tileCarryIn && !cascadeMode && !holdFirstOperand;
  a_gate_low_holds: assert property (!sliceClockGate |=> $stable(result) && $stable(tileCarryOut))
    else $error("result moved while gated off");
  a_carry_outs_agree: assert property (tileCarryOut == cascadeCarryOut)
    else $error("carry outputs differ");
  a_reset_clears: assert property (disable iff (1'b0) srst |=> result == '0 && !tileCarryOut)
    else $error("reset did not clear");
  a_sign_unsigned: assert property (sliceClockGate && !signedOps |=> !signExtendToNext)
    else $error("sign out without signed mode");
  a_add32_result: assert property ((base && mode == MAC_ADD32 && !lowerAccLoadSelect) ##1
    (base && mode == MAC_ADD32 && !lowerAccLoadSelect && $stable(ops)) |=> result ==
    ($past(lowerAccSubSelect) ? $past(ops[31:0]) - $past(ops[63:32])
    : $past(ops[31:0]) + $past(ops[63:32])))
    else $error("wide add or subtract wrong");
  a_mac16_step: assert property ((base && mode == MAC_MAC16 && !signedOps
    && !lowerAccLoadSelect && !lowerAccSubSelect)[*2] ##0 $stable(ops) |=>
    result == $past(result) + $past(opA) * $past(opB))
    else $error("accumulate step wrong");
  a_load_lower: assert property ((sliceClockGate && mode == MAC_ACC16 && lowerAccLoadSelect)[*2]
    ##0 $stable(opC) |=> result[15:0] == $past(opC))
    else $error("lower load wrong");
  a_mul8_upper: assert property ((base && mode == MAC_MUL8 && !signedOps)[*2] ##0 $stable(ops)
    |=> result[31:16] == $past(opA[7:0]) * $past(opB[7:0]))
    else $error("narrow product wrong");
  c_mac16: cover property (mode == MAC_MAC16 && sliceClockGate);
  c_gated: cover property (!sliceClockGate ##1 !sliceClockGate);
  c_carry: cover property (tileCarryOut);
endmodule : mac_slice_sva
bind mac_slice mac_slice_sva u_sva (.*);

// >>> tb/test_mac_slice_datapath.sv
// Self-checking bench for the multiply-accumulate slice
`timescale 1ns/1ps
module test_mac_slice_datapath;
  import mac_pkg::*;
  logic clock = 0, srst = 1, signedOps = 0, cascadeMode = 0, sliceClockGate = 1;
  logic holdFirstOperand = 0, lowerAccLoadSelect = 0, lowerAccSubSelect = 0, linkLevel = 0;
  logic [15:0] opA = 0, opB = 0, opC = 0, opD = 0;
  logic [63:0] v;
  logic [31:0] r, result;
  logic cascadeCarryIn, tileCarryIn, signExtendFromPrev;
  logic cascadeCarryOut, tileCarryOut, signExtendToNext;
  mac_mode_e mode = MAC_ADD32;
  mac_half_ctrl_s upperAccCtrl = '0;
  int bad_count = 0, compares = 0, cycles = 0, seed;
  mac_slice DUT (.*);
  mac_link_model u_link (.*);
  // Free-running clock and hang guard
  always #2.5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  task tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task chk(string what, logic [31:0] want, logic [31:0] got);
    compares++;
    if (got !== want)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, want, got);
    end
  endtask : chk
  // Drive a mode and operands, then allow capture plus accumulate edges
  task go(mac_mode_e m, logic sub, logic [63:0] o);
    mode = m;
    lowerAccSubSelect = sub;
    {opA, opB, opC, opD} = o;
    tick(3);
  endtask : go
  // Borrow or carry in applies after the operand word
  function logic [31:0] addsub(logic [63:0] o, logic sub, logic cin);
    return sub ? o[31:0] - o[63:32] - cin : o[31:0] + o[63:32] + cin;
  endfunction : addsub
  task give_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // Main sequence: corner cases among random wide sums
  initial
  begin
    seed = $urandom(32'h9c66);
    tick(16);
    srst = 0;
    chk("reset result", 0, result);
    repeat (24)
    begin
      v = {$urandom, $urandom};
      r[0] = $urandom;
      go(MAC_ADD32, r[0], v);
      chk("add32", addsub(v, r[0], 0), result);
    end
    go(MAC_ADD32, 0, {32'hFFFF_FFFF, 32'h0000_0001});
    chk("carry out", 1, {31'h0, cascadeCarryOut});
    chk("tile carry out", 1, {31'h0, tileCarryOut});
    for (int cm = 0; cm < 2; cm++)
    begin
      cascadeMode = cm[0];
      linkLevel = 1;
      go(MAC_ADD32, 1, {32'h0000_0010, 32'h0000_0100});
      chk("borrow in", 32'h0000_00EF, result);
    end
    cascadeMode = 0;
    linkLevel = 0;
    go(MAC_MAC16, 0, {16'h0003, 16'h0004, 32'h0});
    r = result;
    tick(1);
    chk("mac step", r + 12, result);
    lowerAccSubSelect = 1;
    tick(1);
    chk("mac sub", r, result);
    sliceClockGate = 0;
    opA = $urandom;
    tick(4);
    chk("gated", r, result);
    sliceClockGate = 1;
    go(MAC_ADD32, 0, {16'h1111, 48'h0});
    holdFirstOperand = 1;
    opA = 16'h2222;
    tick(3);
    chk("held A", 32'h1111_0000, result);
    holdFirstOperand = 0;
    tick(3);
    chk("freed A", 32'h2222_0000, result);
    lowerAccLoadSelect = 1;
    upperAccCtrl = '{loadSel: 1'b1, subSel: 1'b0};
    go(MAC_ACC16, 0, {32'h0, 16'h1234, 16'h5678});
    chk("load", 32'h5678_1234, result);
    lowerAccLoadSelect = 0;
    upperAccCtrl = '0;
    repeat (8)
    begin
      v = {$urandom, $urandom};
      go(MAC_MUL8, 0, v);
      chk("mul8", v[55:48] * v[39:32], {16'h0, result[31:16]});
    end
    // Split halves: upper subtracts C-A on its own controls, lower adds D+B
    upperAccCtrl = '{loadSel: 1'b0, subSel: 1'b1};
    go(MAC_ADD16, 0, {16'h0003, 16'h0005, 16'h0010, 16'h0020});
    chk("add16", 32'h000D_0025, result);
    upperAccCtrl = '0;
    // Subtract select is ignored by a plain multiply
    go(MAC_MUL16, 1, {16'hFFFE, 16'h0003, 32'h0});
    chk("mul16 unsigned", 32'h0002_FFFA, result);
    signedOps = 1;
    go(MAC_ADD32, 0, {16'h8000, 48'h0});
    chk("sign out", 1, {31'h0, signExtendToNext});
    go(MAC_MUL16, 0, {16'hFFFE, 16'h0003, 32'h0});
    chk("mul16 signed", 32'hFFFF_FFFA, result);
    give_verdict();
  end
endmodule : test_mac_slice_datapath
